// ### hw/tmb_regs.svh
// Register indices, field positions, reset values and timing counts of timer B
`ifndef TMB_REGS_SVH
`define TMB_REGS_SVH
`define TMB_IDX_CONTROL_A 4'h0
`define TMB_IDX_CONTROL_B 4'h1
`define TMB_IDX_EVENT_CONTROL 4'h4
`define TMB_IDX_INT_ENABLE 4'h5
`define TMB_IDX_INT_FLAGS 4'h6
`define TMB_IDX_RUN_STATUS 4'h7
`define TMB_IDX_DEBUG_CONTROL 4'h8
`define TMB_IDX_WIDE_TEMP 4'h9
`define TMB_IDX_COUNTER 4'hA
`define TMB_IDX_COMPARE 4'hC
`define TMB_A_ENABLE 0
`define TMB_A_CLOCK_SOURCE_SELECT_HI 2
`define TMB_A_CLOCK_SOURCE_SELECT_LO 1
`define TMB_A_SYNC_RESTART 4
`define TMB_A_RUN_STANDBY 6
`define TMB_B_MODE_HI 2
`define TMB_B_GATE 4
`define TMB_B_INIT_LEVEL 5
`define TMB_B_OUTPUT_BIT_A 6
`define TMB_EV_INPUT_EN 0
`define TMB_EV_EDGE 4
`define TMB_EV_FILTER 6
`define TMB_FLAG_CAPTURE 0
`define TMB_DBG_RUN 0
`define TMB_MASK_CONTROL_A 8'h57
`define TMB_MASK_CONTROL_B 8'h77
`define TMB_MASK_EVENT 8'h51
`define TMB_MASK_ONE_BIT 8'h01
`define TMB_CLK_PERIPH 2'h0
`define TMB_CLK_PERIPH_DIV2 2'h1
`define TMB_CLK_TIMER_A 2'h2
`define TMB_CLK_RESERVED 2'h3
`define TMB_RST_BYTE 8'h00
`define TMB_RST_WORD 16'h0000
`define TMB_FILTER_LEN 4
`endif

// ### hw/tmb_pkg.sv
// Types shared by the timer B design files
package tmb_pkg;
  typedef enum logic [2:0] {
    MODE_PERIODIC = 3'h0,
    MODE_TIMEOUT = 3'h1,
    MODE_CAPTURE = 3'h2,
    MODE_FREQ = 3'h3,
    MODE_PULSE = 3'h4,
    MODE_FREQ_PULSE = 3'h5,
    MODE_SINGLE = 3'h6,
    MODE_PWM8 = 3'h7
  } tmb_mode_t;
  typedef enum logic [3:0] {
    FPW_ARM = 4'h1,
    FPW_OPP = 4'h2,
    FPW_SECOND = 4'h4,
    FPW_DONE = 4'h8
  } tmb_fpw_t;
  typedef struct packed {
    logic wr;
    logic rd;
    logic [3:0] idx;
    logic [31:0] wdata;
  } tmb_bus_req_t;
  typedef struct packed {
    logic rise;
    logic fall;
  } tmb_edges_t;
endpackage

// ### hw/tmb_evt_filter.sv
// Event input noise canceller and edge detector
`include "tmb_regs.svh"
module tmb_evt_filter
  import tmb_pkg::*;
(
  input wire logic clk,
  input wire logic reset_n,
  input wire logic event_in,
  input wire logic filter_en,
  output tmb_edges_t edges
);
  logic [`TMB_FILTER_LEN-1:0] hist_q;
  logic lvl_q;
  logic prev_q;
  wire stable = (&hist_q) | ~(|hist_q);
  wire lvl_d = filter_en ? (stable ? hist_q[`TMB_FILTER_LEN-1] : lvl_q) : event_in;

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      hist_q <= '0;
      lvl_q <= 1'b0;
      prev_q <= 1'b0;
    end else begin
      hist_q <= {hist_q[`TMB_FILTER_LEN-2:0], event_in};
      lvl_q <= lvl_d;
      prev_q <= lvl_q;
    end
  end

  assign edges.rise = lvl_q & ~prev_q;
  assign edges.fall = ~lvl_q & prev_q;
endmodule

// ### hw/tmb_ahb_slave.sv
// AHB-Lite slave front end: one word per register, one wait state on reads
module tmb_ahb_slave
  import tmb_pkg::*;
(
  input wire logic clk,
  input wire logic reset_n,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  output tmb_bus_req_t req,
  input wire logic [31:0] rdata
);
  logic ph_valid_q;
  logic ph_write_q;
  logic ph_hit_q;
  logic [3:0] ph_idx_q;
  logic rd_wait_q;
  wire accept = hsel & htrans[1] & hready;
  wire word_hit = (haddr[31:6] == 26'h0000000) & (hsize == 3'h2);

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      ph_valid_q <= 1'b0;
      ph_write_q <= 1'b0;
      ph_hit_q <= 1'b0;
      ph_idx_q <= 4'h0;
      rd_wait_q <= 1'b0;
      hrdata <= 32'h00000000;
    end else begin
      if (accept) begin
        ph_valid_q <= 1'b1;
        ph_write_q <= hwrite;
        ph_hit_q <= word_hit;
        ph_idx_q <= haddr[5:2];
      end else if (hready) begin
        ph_valid_q <= 1'b0;
      end
      rd_wait_q <= accept & ~hwrite;
      if (rd_wait_q) begin
        hrdata <= ph_hit_q ? rdata : 32'h00000000;
      end
    end
  end

  assign hreadyout = ~rd_wait_q;
  assign hresp = 1'b0;
  assign req.wr = ph_valid_q & ph_write_q & ph_hit_q;
  assign req.rd = rd_wait_q & ph_hit_q;
  assign req.idx = ph_idx_q;
  assign req.wdata = hwdata;
endmodule

// ### hw/tmb_timer.sv
// Timer B top: registers, count clock, event actions, capture flag and output
//
// Function
// [RULE_01] One capture interrupt source, vector zero
// [RULE_02] Flag sets regardless of interrupt enable
// [RULE_03] Request while enable and flag both set
// [RULE_04] Power-down sleep halts all activity
// [RULE_05] Standby runs only with run-in-standby bit; the code also runs in standby when clock select is timer A
// [RULE_06] Sync restart follows timer A restart
// [RULE_07] Clock select picks count clock source
// [RULE_08] Timer operates only while enabled
// [RULE_09] Single-shot output high on start or event
// [RULE_10] Initial level bit sets idle output
// [RULE_11] Output gate forces output low
// [RULE_12] Mode field selects one of eight modes
// [RULE_13] Filter bit enables event noise canceller
// [RULE_14] Periodic and PWM ignore event edges
// [RULE_15] Time-out: one edge starts, other stops
// [RULE_16] Capture mode: selected edge captures, interrupts
// [RULE_17] Frequency: capture, clear, restart, interrupt
// [RULE_18] Pulse width: restart edge, capture edge
// [RULE_19] Freq plus width: restart, capture, stop
// [RULE_20] Single-shot start edges follow edge bit
// [RULE_21] Flag clears by write-one or capture read
// [RULE_22] Flag set also strobes event output
// [RULE_23] Events act only with input enable
// [RULE_24] Run status shows counter running
// [RULE_25] Reserved clock select gives no clock
`include "tmb_regs.svh"
module tmb_timer
  import tmb_pkg::*;
(
  input wire logic clk,
  input wire logic reset_n,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire logic event_in,
  input wire logic timer_a_clk_en,
  input wire logic timer_a_restart,
  input wire logic sleep_standby,
  input wire logic sleep_power_down,
  input wire logic debug_halt,
  output logic irq,
  output logic wave_out,
  output logic event_out
);
  tmb_bus_req_t req;
  tmb_edges_t edges;
  logic [31:0] rdata;

  logic [7:0] ctla_q;
  logic [7:0] ctlb_q;
  logic [7:0] evc_q;
  logic [7:0] ie_q;
  logic [7:0] dbg_q;
  logic [7:0] tmp_q;
  logic flag_q;
  logic [15:0] cnt_q;
  logic [15:0] compare_capture_value_q;
  logic run_q;
  logic div_q;
  logic raw_prev_q;
  logic ss_pend_q;
  logic ss_out_q;
  logic wave_q;
  logic evout_q;
  tmb_fpw_t fpw_q;

  logic [15:0] cnt_d;
  logic run_d;
  logic set_cap;
  logic cap_ld;
  tmb_fpw_t fpw_d;
  logic ss_out_d;

  function automatic logic wr_hit(input tmb_bus_req_t r, input logic [3:0] idx);
    wr_hit = r.wr & (r.idx == idx);
  endfunction

  function automatic logic rd_hit(input tmb_bus_req_t r, input logic [3:0] idx);
    rd_hit = r.rd & (r.idx == idx);
  endfunction

  tmb_ahb_slave u_bus (
    .clk(clk),
    .reset_n(reset_n),
    .hsel(hsel),
    .haddr(haddr),
    .htrans(htrans),
    .hwrite(hwrite),
    .hsize(hsize),
    .hwdata(hwdata),
    .hready(hready),
    .hreadyout(hreadyout),
    .hresp(hresp),
    .hrdata(hrdata),
    .req(req),
    .rdata(rdata)
  );

  // [RULE_13] Noise canceller switch
  tmb_evt_filter u_filter (
    .clk(clk),
    .reset_n(reset_n),
    .event_in(event_in),
    .filter_en(evc_q[`TMB_EV_FILTER]),
    .edges(edges)
  );

  // Field decode
  wire tmb_mode_t mode = tmb_mode_t'(ctlb_q[`TMB_B_MODE_HI:0]);
  wire [1:0] clock_source_select = ctla_q[`TMB_A_CLOCK_SOURCE_SELECT_HI:`TMB_A_CLOCK_SOURCE_SELECT_LO];
  wire enable = ctla_q[`TMB_A_ENABLE];
  wire edge_bit = evc_q[`TMB_EV_EDGE];
  wire output_bit_a_bit = ctlb_q[`TMB_B_OUTPUT_BIT_A];
  wire gate_bit = ctlb_q[`TMB_B_GATE];
  wire capture_mode = (mode == MODE_CAPTURE) | (mode == MODE_FREQ) | (mode == MODE_PULSE) |
                      (mode == MODE_FREQ_PULSE);

  // [RULE_04] [RULE_05] Sleep and debug halt gating
  wire standby_ok = ctla_q[`TMB_A_RUN_STANDBY] | (clock_source_select == `TMB_CLK_TIMER_A);
  wire awake = ~sleep_power_down & (~sleep_standby | standby_ok) &
               (~debug_halt | dbg_q[`TMB_DBG_RUN]);
  // [RULE_08] Enable gates count ticks, event inputs and the divide-by-two clock
  wire live = enable & awake;

  // [RULE_07] [RULE_25] Count clock source
  wire src_tick = (clock_source_select == `TMB_CLK_PERIPH) ? 1'b1 :
                  (clock_source_select == `TMB_CLK_PERIPH_DIV2) ? div_q :
                  (clock_source_select == `TMB_CLK_TIMER_A) ? timer_a_clk_en : 1'b0;
  wire tick = live & src_tick;

  // [RULE_23] Event input enable
  wire ev_ok = live & evc_q[`TMB_EV_INPUT_EN];
  wire ev_rise = ev_ok & edges.rise;
  wire ev_fall = ev_ok & edges.fall;
  wire ev_sel = edge_bit ? ev_fall : ev_rise;
  wire ev_opp = edge_bit ? ev_rise : ev_fall;

  // [RULE_20] Single-shot start edges
  wire ss_trig = ev_rise | (edge_bit & ev_fall);
  wire ss_mode = (mode == MODE_SINGLE);
  wire ss_go = ss_mode & ~run_q & ~ss_pend_q & ss_trig;
  wire raw_rise = event_in & ~raw_prev_q;
  wire raw_fall = ~event_in & raw_prev_q;
  // [RULE_09] Asynchronous single-shot output set
  wire ss_output_bit_a_set = ss_mode & output_bit_a_bit & gate_bit & ev_ok & ~run_q & ~ss_pend_q &
                      (raw_rise | (edge_bit & raw_fall));

  wire top_hit = (cnt_q == compare_capture_value_q);
  wire pwm_top = (cnt_q[7:0] == compare_capture_value_q[7:0]);
  wire [15:0] cnt_inc = cnt_q + 16'h0001;

  // [RULE_21] Flag clear sources
  wire clr_cap = (wr_hit(req, `TMB_IDX_INT_FLAGS) & req.wdata[`TMB_FLAG_CAPTURE]) |
                 (rd_hit(req, `TMB_IDX_COMPARE) & capture_mode);

  // [RULE_12] Per-mode event and count actions
  always_comb begin
    cnt_d = cnt_q;
    run_d = run_q;
    fpw_d = fpw_q;
    set_cap = 1'b0;
    cap_ld = 1'b0;
    case (mode)
      // [RULE_14] Periodic counts, edges unused
      MODE_PERIODIC: begin
        run_d = live;
        if (tick) begin
          if (top_hit) begin
            cnt_d = 16'h0000;
            set_cap = 1'b1;
          end else begin
            cnt_d = cnt_inc;
          end
        end
      end
      // [RULE_15] Start and stop edges
      MODE_TIMEOUT: begin
        if (ev_sel) begin
          run_d = 1'b1;
        end else if (ev_opp) begin
          run_d = 1'b0;
        end
        if (tick & run_q) begin
          if (top_hit) begin
            cnt_d = 16'h0000;
            set_cap = 1'b1;
          end else begin
            cnt_d = cnt_inc;
          end
        end
      end
      // [RULE_16] Capture on selected edge
      MODE_CAPTURE: begin
        run_d = live;
        if (tick) begin
          cnt_d = cnt_inc;
        end
        if (ev_sel) begin
          cap_ld = 1'b1;
          set_cap = 1'b1;
        end
      end
      // [RULE_17] Capture and restart
      MODE_FREQ: begin
        run_d = live;
        if (tick) begin
          cnt_d = cnt_inc;
        end
        if (ev_sel) begin
          cap_ld = 1'b1;
          set_cap = 1'b1;
          cnt_d = 16'h0000;
        end
      end
      // [RULE_18] Restart edge then capture edge
      MODE_PULSE: begin
        run_d = live;
        if (tick) begin
          cnt_d = cnt_inc;
        end
        if (ev_sel) begin
          cnt_d = 16'h0000;
        end
        if (ev_opp) begin
          cap_ld = 1'b1;
          set_cap = 1'b1;
        end
      end
      // [RULE_19] Three-edge sequence
      MODE_FREQ_PULSE: begin
        case (fpw_q)
          FPW_ARM: begin
            if (ev_sel) begin
              cnt_d = 16'h0000;
              fpw_d = FPW_OPP;
            end
          end
          FPW_OPP: begin
            if (tick) begin
              cnt_d = cnt_inc;
            end
            if (ev_opp) begin
              cap_ld = 1'b1;
              fpw_d = FPW_SECOND;
            end
          end
          FPW_SECOND: begin
            if (tick) begin
              cnt_d = cnt_inc;
            end
            if (ev_sel) begin
              set_cap = 1'b1;
              fpw_d = FPW_DONE;
            end
          end
          FPW_DONE: begin
            if (clr_cap) begin
              fpw_d = FPW_ARM;
            end
          end
          default: begin
            fpw_d = FPW_ARM;
          end
        endcase
        run_d = live & ((fpw_d == FPW_OPP) | (fpw_d == FPW_SECOND));
      end
      // [RULE_09] Single-shot start after event
      MODE_SINGLE: begin
        if (~run_q & ss_pend_q) begin
          cnt_d = 16'h0000;
          run_d = 1'b1;
        end else if (run_q & tick) begin
          if (top_hit) begin
            run_d = 1'b0;
            set_cap = 1'b1;
          end else begin
            cnt_d = cnt_inc;
          end
        end
      end
      // [RULE_14] PWM counts, edges unused
      MODE_PWM8: begin
        run_d = live;
        if (tick) begin
          if (pwm_top) begin
            cnt_d = 16'h0000;
            set_cap = 1'b1;
          end else begin
            cnt_d = cnt_inc;
          end
        end
      end
      default: begin
        run_d = 1'b0;
      end
    endcase
    if (mode != MODE_FREQ_PULSE) begin
      fpw_d = FPW_ARM;
    end
    // [RULE_08] Stopped while disabled
    if (!enable) begin
      run_d = 1'b0;
    end
    // [RULE_06] Follow timer A restart
    if (ctla_q[`TMB_A_SYNC_RESTART] & timer_a_restart & live) begin
      cnt_d = 16'h0000;
    end
    if (wr_hit(req, `TMB_IDX_COUNTER)) begin
      cnt_d = req.wdata[15:0];
    end
  end

  // Single-shot output level
  always_comb begin
    ss_out_d = ss_out_q;
    if (output_bit_a_bit & ss_go) begin
      ss_out_d = 1'b1;
    end
    if (~run_q & ss_pend_q) begin
      ss_out_d = 1'b1;
    end
    if (run_q & tick & top_hit) begin
      ss_out_d = 1'b0;
    end
    if (!enable | !ss_mode) begin
      ss_out_d = 1'b0;
    end
  end

  // PWM high for the first compare-high counts of each period
  wire pwm_level = (compare_capture_value_q[7:0] != 8'h00) & (cnt_q < {8'h00, compare_capture_value_q[15:8]});
  // [RULE_10] Idle level outside single-shot and PWM
  wire out_val = ss_mode ? ss_out_q :
                 (mode == MODE_PWM8) ? (enable & pwm_level) : ctlb_q[`TMB_B_INIT_LEVEL];

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      cnt_q <= `TMB_RST_WORD;
      run_q <= 1'b0;
      fpw_q <= FPW_ARM;
      ss_pend_q <= 1'b0;
      ss_out_q <= 1'b0;
      raw_prev_q <= 1'b0;
      div_q <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      run_q <= run_d;
      fpw_q <= fpw_d;
      ss_pend_q <= ss_go;
      ss_out_q <= ss_out_d;
      raw_prev_q <= event_in;
      div_q <= live & ~div_q;
    end
  end

  // [RULE_02] [RULE_21] Flag: set wins over clear
  wire flag_d = set_cap | (flag_q & ~clr_cap);

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      flag_q <= 1'b0;
      evout_q <= 1'b0;
      wave_q <= 1'b0;
    end else begin
      flag_q <= flag_d;
      // [RULE_22] One-cycle event strobe
      evout_q <= set_cap;
      // [RULE_11] Output gate
      wave_q <= gate_bit & out_val;
    end
  end

  // Control register writes
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      ctla_q <= `TMB_RST_BYTE;
      ctlb_q <= `TMB_RST_BYTE;
      evc_q <= `TMB_RST_BYTE;
      ie_q <= `TMB_RST_BYTE;
      dbg_q <= `TMB_RST_BYTE;
      tmp_q <= `TMB_RST_BYTE;
    end else begin
      if (wr_hit(req, `TMB_IDX_CONTROL_A)) begin
        ctla_q <= req.wdata[7:0] & `TMB_MASK_CONTROL_A;
      end
      if (wr_hit(req, `TMB_IDX_CONTROL_B)) begin
        ctlb_q <= req.wdata[7:0] & `TMB_MASK_CONTROL_B;
      end
      if (wr_hit(req, `TMB_IDX_EVENT_CONTROL)) begin
        evc_q <= req.wdata[7:0] & `TMB_MASK_EVENT;
      end
      if (wr_hit(req, `TMB_IDX_INT_ENABLE)) begin
        ie_q <= req.wdata[7:0] & `TMB_MASK_ONE_BIT;
      end
      if (wr_hit(req, `TMB_IDX_DEBUG_CONTROL)) begin
        dbg_q <= req.wdata[7:0] & `TMB_MASK_ONE_BIT;
      end
      if (wr_hit(req, `TMB_IDX_WIDE_TEMP)) begin
        tmp_q <= req.wdata[7:0];
      end
    end
  end

  // Compare write has priority over a capture load
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      compare_capture_value_q <= `TMB_RST_WORD;
    end else if (wr_hit(req, `TMB_IDX_COMPARE)) begin
      compare_capture_value_q <= req.wdata[15:0];
    end else if (cap_ld) begin
      compare_capture_value_q <= cnt_q;
    end
  end

  // Read mux, unmapped words read zero
  always_comb begin
    case (req.idx)
      `TMB_IDX_CONTROL_A: rdata = {24'h000000, ctla_q};
      `TMB_IDX_CONTROL_B: rdata = {24'h000000, ctlb_q};
      `TMB_IDX_EVENT_CONTROL: rdata = {24'h000000, evc_q};
      `TMB_IDX_INT_ENABLE: rdata = {24'h000000, ie_q};
      `TMB_IDX_INT_FLAGS: rdata = {31'h00000000, flag_q};
      // [RULE_24] Run status
      `TMB_IDX_RUN_STATUS: rdata = {31'h00000000, run_q};
      `TMB_IDX_DEBUG_CONTROL: rdata = {24'h000000, dbg_q};
      `TMB_IDX_WIDE_TEMP: rdata = {24'h000000, tmp_q};
      `TMB_IDX_COUNTER: rdata = {16'h0000, cnt_q};
      `TMB_IDX_COMPARE: rdata = {16'h0000, compare_capture_value_q};
      default: rdata = 32'h00000000;
    endcase
  end

  // [RULE_01] [RULE_03] Capture interrupt request
  assign irq = flag_q & ie_q[`TMB_FLAG_CAPTURE];
  assign event_out = evout_q;
  assign wave_out = wave_q | ss_output_bit_a_set;
endmodule

// ### dv/tmb_timer_monitor.sv
// Concurrent checks on the timer B top ports
module tmb_timer_monitor (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic hsel,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic hready,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic irq,
  input wire logic wave_out,
  input wire logic event_out,
  input wire logic sleep_power_down
);
  default clocking @(posedge clk);
  endclocking
  default disable iff (!reset_n);
  wire take = hsel & htrans[1] & hready;
  sequence s_rd;
    take && !hwrite;
  endsequence
  sequence s_wait;
    !hreadyout ##1 hreadyout;
  endsequence
  property p_rd_wait;
    s_rd |=> s_wait;
  endproperty
  a_rd_wait: assert property (p_rd_wait) else $error("read wait state wrong");
  property p_wr_now;
    take && hwrite |=> hreadyout;
  endproperty
  a_wr_now: assert property (p_wr_now) else $error("write stalled");
  property p_okay;
    !hresp;
  endproperty
  a_okay: assert property (p_okay) else $error("response not okay");
  property p_strobe;
    event_out |=> !event_out;
  endproperty
  a_strobe: assert property (p_strobe) else $error("event strobe too long");
  property p_irq_fall;
    $fell(irq) |-> $past(take, 2);
  endproperty
  a_irq_fall: assert property (p_irq_fall) else $error("irq dropped without access");
  property p_irq_rise;
    $rose(irq) |-> event_out || $past(take, 2);
  endproperty
  a_irq_rise: assert property (p_irq_rise) else $error("irq rose without cause");
  property p_pdown;
    sleep_power_down && $past(sleep_power_down) && $past(sleep_power_down, 2) |-> !event_out;
  endproperty
  a_pdown: assert property (p_pdown) else $error("event in power down");
  property p_reset;
    $rose(reset_n) |-> !irq && !event_out && !wave_out;
  endproperty
  a_reset: assert property (p_reset) else $error("outputs not idle after reset");
endmodule

bind tmb_timer tmb_timer_monitor i_mon (.clk, .reset_n, .hsel, .htrans, .hwrite, .hready, .hreadyout,
  .hresp, .irq, .wave_out, .event_out, .sleep_power_down);

// ### dv/tmb_peer_model.sv
// Event source and companion timer A stand-in
module tmb_peer_model (
  input wire logic clk,
  output logic event_in,
  output logic timer_a_clk_en,
  output logic timer_a_restart
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [1:0] tick_q = 2'h0;
  initial begin
    event_in = 1'b0;
    timer_a_clk_en = 1'b0;
    timer_a_restart = 1'b0;
  end
  // Timer A ticks every fourth cycle
  always @(posedge clk) begin
    tick_q <= tick_q + 2'h1;
    timer_a_clk_en <= (tick_q == 2'h3);
  end
  task automatic drive(input logic lvl);
    @(posedge clk);
    event_in <= lvl;
    repeat (3) @(posedge clk);
  endtask
  task automatic restart_a();
    @(posedge clk);
    timer_a_restart <= 1'b1;
    @(posedge clk);
    timer_a_restart <= 1'b0;
  endtask
endmodule

// ### dv/tb_timer_b_control_events.sv
// Self-checking bench for the timer B top
module tb_timer_b_control_events;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk, reset_n, hsel, hwrite, event_in, ta_clk, ta_rst;
  logic sleep_standby, sleep_power_down, debug_halt;
  logic hreadyout, hresp, irq, wave_out, event_out;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [31:0] haddr, hwdata, hrdata, rd_v, v2;
  int fail_count = 0;
  int n_tests = 0;
  int n_ev = 0;
  tmb_timer i_dut (.clk, .reset_n, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
    .hready(hreadyout), .hreadyout, .hresp, .hrdata, .event_in, .timer_a_clk_en(ta_clk),
    .timer_a_restart(ta_rst), .sleep_standby, .sleep_power_down, .debug_halt, .irq,
    .wave_out, .event_out);
  tmb_peer_model i_peer (.clk, .event_in, .timer_a_clk_en(ta_clk), .timer_a_restart(ta_rst));
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  always @(negedge clk) begin
    if (event_out === 1'b1) n_ev++;
  end
  task automatic close_out();
    $display("checks %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_tests++;
    if (g !== e) begin
      fail_count++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask
  // Pin check once registered outputs settle
  task automatic pk(input string nm, input logic e, ref logic s);
    repeat (2) @(posedge clk);
    @(negedge clk);
    chk(nm, 32'(e), 32'(s));
    @(posedge clk);
  endtask
  task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] d, input logic [2:0] sz,
                     output logic [31:0] q);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= w;
    hsize <= sz;
    do @(negedge clk); while (hreadyout !== 1'b1);
    @(posedge clk);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(negedge clk); while (hreadyout !== 1'b1);
    q = hrdata;
    @(posedge clk);
  endtask
  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, 3'h2, q);
  endtask
  task automatic rd(input logic [31:0] a, output logic [31:0] q);
    bus(1'b0, a, 32'h0, 3'h2, q);
  endtask
  task automatic t_regs();
    logic [31:0] ad[11] = '{32'h0, 32'h4, 32'h8, 32'h10, 32'h14, 32'h18, 32'h1C, 32'h20, 32'h24,
      32'h28, 32'h30};
    foreach (ad[i]) begin
      rd(ad[i], rd_v);
      chk("reset_value", 32'h0, rd_v);
    end
    wr(32'h00, 32'hFF);
    rd(32'h00, rd_v);
    chk("ctrl_a_bits", 32'h57, rd_v);
    wr(32'h00, 32'h00);
    wr(32'h1C, 32'h01);
    rd(32'h1C, rd_v);
    chk("status_ro", 32'h0, rd_v);
    wr(32'h30, 32'h1FFFF);
    rd(32'h30, rd_v);
    chk("compare_width", 32'hFFFF, rd_v);
    // Byte-size access refused
    bus(1'b1, 32'h30, 32'h1234, 3'h0, rd_v);
    bus(1'b0, 32'h30, 32'h0, 3'h0, v2);
    chk("byte_read_zero", 32'h0, v2);
    rd(32'h30, rd_v);
    chk("byte_write_ignored", 32'hFFFF, rd_v);
  endtask
  task automatic t_capture();
    n_ev = 0;
    wr(32'h04, 32'h02);
    wr(32'h00, 32'h01);
    i_peer.drive(1'b1);
    rd(32'h18, rd_v);
    chk("flag_input_off", 32'h0, rd_v);
    i_peer.drive(1'b0);
    wr(32'h10, 32'h01);
    i_peer.drive(1'b1);
    rd(32'h18, rd_v);
    chk("flag_rise", 32'h1, rd_v);
    pk("irq_masked", 1'b0, irq);
    wr(32'h14, 32'h01);
    pk("irq_on", 1'b1, irq);
    rd(32'h30, rd_v);
    pk("irq_capture_read", 1'b0, irq);
    wr(32'h10, 32'h11);
    i_peer.drive(1'b0);
    pk("irq_fall_edge", 1'b1, irq);
    wr(32'h18, 32'h01);
    pk("irq_w1c", 1'b0, irq);
    i_peer.drive(1'b1);
    pk("irq_rise_ignored", 1'b0, irq);
    chk("strobe_count", 32'h2, 32'(n_ev));
  endtask
  task automatic t_freq();
    wr(32'h04, 32'h03);
    wr(32'h10, 32'h01);
    i_peer.drive(1'b0);
    repeat (50) @(posedge clk);
    i_peer.drive(1'b1);
    rd(32'h28, rd_v);
    chk("freq_restart", 32'h1, 32'(rd_v < 32'd20));
    rd(32'h18, rd_v);
    chk("freq_flag", 32'h1, rd_v);
    wr(32'h18, 32'h01);
  endtask
  task automatic t_clock_source_select();
    logic [31:0] d[4];
    // Top far away so periodic mode does not wrap
    wr(32'h30, 32'hFFFF);
    wr(32'h04, 32'h00);
    for (int s = 0; s < 4; s++) begin
      wr(32'h00, 32'(s * 2 + 1));
      rd(32'h28, rd_v);
      repeat (40) @(posedge clk);
      rd(32'h28, v2);
      d[s] = v2 - rd_v;
    end
    chk("div1_faster", 32'h1, 32'(d[0] > d[1]));
    chk("div2_faster", 32'h1, 32'(d[1] > d[2]));
    chk("timer_a_ticks", 32'h1, 32'(d[2] > 0));
    chk("reserved_frozen", 32'h0, d[3]);
  endtask
  task automatic t_sync();
    for (int s = 0; s < 2; s++) begin
      wr(32'h00, 32'(s * 16 + 1));
      repeat (40) @(posedge clk);
      i_peer.restart_a();
      rd(32'h28, rd_v);
      chk("sync_restart", 32'(s), 32'(rd_v < 32'd20));
    end
  endtask
  task automatic t_halt();
    for (int i = 0; i < 4; i++) begin
      wr(32'h00, i == 3 ? 32'h41 : 32'h01);
      {debug_halt, sleep_standby, sleep_power_down} <= 3'(i == 3 ? 2 : 1 << i);
      repeat (3) @(posedge clk);
      rd(32'h28, rd_v);
      rd(32'h28, v2);
      chk("count_in_halt", 32'(i == 3), 32'(v2 != rd_v));
      {debug_halt, sleep_standby, sleep_power_down} <= 3'h0;
    end
  endtask
  task automatic t_shot();
    wr(32'h00, 32'h00);
    wr(32'h28, 32'h00);
    wr(32'h04, 32'h16);
    wr(32'h00, 32'h01);
    i_peer.drive(1'b0);
    rd(32'h1C, rd_v);
    chk("shot_idle", 32'h0, rd_v);
    pk("shot_out_low", 1'b0, wave_out);
    i_peer.drive(1'b1);
    pk("shot_out_high", 1'b1, wave_out);
    rd(32'h1C, rd_v);
    chk("shot_running", 32'h1, rd_v);
  endtask
  initial begin
    reset_n = 1'b0;
    {hsel, sleep_standby, sleep_power_down, debug_halt} = 4'h0;
    htrans = 2'h0;
    repeat (6) @(posedge clk);
    reset_n <= 1'b1;
    @(posedge clk);
    t_regs();
    t_capture();
    t_freq();
    t_clock_source_select();
    t_sync();
    t_halt();
    t_shot();
    close_out();
  end
  // Whole run needs several hundred cycles
  initial begin
    #100us;
    fail_count++;
    close_out();
  end
endmodule
